// >>> tws_regs.svh
// Register offsets, field positions, reset values and timing counts of the two-wire slave
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_OFF_CTRL     8'h00
`define TWS_OFF_STATUS   8'h04
`define TWS_OFF_TXDATA   8'h08
`define TWS_OFF_RXDATA   8'h0C
`define TWS_CTRL_ADDR_LO 0
`define TWS_CTRL_ADDR_HI 6
`define TWS_CTRL_EN      8
`define TWS_CTRL_LIMIT   9
`define TWS_CTRL_FLUSH   10
`define TWS_CTRL_RST     32'h0000_0000
`define TWS_ST_RXFULL    0
`define TWS_ST_TXEMPTY   1
`define TWS_ST_GCALL     2
`define TWS_ST_READ      3
`define TWS_ST_ACTIVE    4
`define TWS_ST_TXFULL    5
`define TWS_ST_RXEMPTY   6
`define TWS_CLK_MHZ      100
`define TWS_HOLD_NS      50
`define TWS_HOLD_CYC     ((`TWS_HOLD_NS * `TWS_CLK_MHZ + 999) / 1000)
`define TWS_BYTE_BITS    4'h8
`endif

// >>> tws_pkg.sv
// Types shared by the two-wire slave
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE    = 3'h0,
    TWS_ADDR    = 3'h1,
    TWS_ADDRACK = 3'h3,
    TWS_RXBYTE  = 3'h2,
    TWS_RXACK   = 3'h6,
    TWS_RXCHK   = 3'h7,
    TWS_TXBYTE  = 3'h5,
    TWS_TXACK   = 3'h4
  } tws_state_e;
endpackage

// >>> tws_slave.sv
// Buffered two-wire bus slave with its own byte shift register, with APB registers
`include "tws_regs.svh"

module tws_fifo
  import tws_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("tws_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always_comb begin
    wr_next  = wr_reg + AW'(push);
    rd_next  = rd_reg + AW'(pop);
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      rd_next  = wr_reg;
      wr_next  = wr_reg;
      cnt_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

module tws_slave
  import tws_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire bus lines, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Power management
  output logic             wake_o,
  output logic             active_o
);
  generate
    if (DEPTH > 255) begin : g_bad
      $error("tws_slave: DEPTH above 255 not supported");
    end
  endgenerate

  // Pin synchronisers; a level counts once stages two and three agree
  logic [2:0] scl_sy, sda_sy;
  logic       scl_f, sda_f, scl_p, sda_p, scl_f_next, sda_f_next;
  always_comb begin
    scl_f_next = (scl_sy[1] == scl_sy[2]) ? scl_sy[2] : scl_f;
    sda_f_next = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_p  <= 1'b1;
      sda_p  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[1:0], scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      scl_f  <= scl_f_next;
      sda_f  <= sda_f_next;
      scl_p  <= scl_f;
      sda_p  <= sda_f;
    end
  end
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_ev  = scl_f & scl_p & ~sda_p & sda_f;

  // APB registers
  logic [31:0] ctrl_reg, ctrl_next, prdata_reg, prdata_next;
  logic        rxfull_reg, rxfull_next, gcall_reg, gcall_next;
  logic        setup, access, done, sel_tx, sel_rx, sel_ctl, sel_st;
  logic        tx_in_ready, tx_valid, tx_pop, tx_flush, rx_ready, rx_valid, rx_push;
  logic        set_full, set_gc;
  logic [7:0]  tx_data, rx_data, sh_reg, sh_next, msg_reg, msg_next;
  logic [6:0]  own_addr;
  tws_state_e  st_reg, st_next;
  logic        dir_reg, dir_next;
  assign sel_ctl  = (paddr == `TWS_OFF_CTRL);
  assign sel_st   = (paddr == `TWS_OFF_STATUS);
  assign sel_tx   = (paddr == `TWS_OFF_TXDATA);
  assign sel_rx   = (paddr == `TWS_OFF_RXDATA);
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign pready   = ~(sel_tx & pwrite) | tx_in_ready;
  assign done     = access & pready;
  assign pslverr  = access & ~(sel_ctl | sel_st | sel_tx | sel_rx);
  assign prdata   = prdata_reg;
  assign own_addr = ctrl_reg[`TWS_CTRL_ADDR_HI:`TWS_CTRL_ADDR_LO];

  always_comb begin
    ctrl_next   = ctrl_reg;
    rxfull_next = rxfull_reg;
    gcall_next  = gcall_reg;
    prdata_next = prdata_reg;
    ctrl_next[`TWS_CTRL_FLUSH] = 1'b0;
    if (done && pwrite && sel_ctl) begin
      ctrl_next = pwdata;
    end
    if (done && pwrite && sel_st) begin
      rxfull_next = rxfull_reg & ~pwdata[`TWS_ST_RXFULL];
      gcall_next  = gcall_reg & ~pwdata[`TWS_ST_GCALL];
    end
    // Hardware set wins over a software clear in the same cycle
    if (set_full) begin
      rxfull_next = 1'b1;
    end
    if (set_gc) begin
      gcall_next = 1'b1;
    end
    if (setup) begin
      prdata_next = 32'h0000_0000;
      if (sel_ctl) begin
        prdata_next = ctrl_reg;
        prdata_next[`TWS_CTRL_FLUSH] = 1'b0;
      end else if (sel_st) begin
        prdata_next[`TWS_ST_RXFULL]  = rxfull_reg;
        prdata_next[`TWS_ST_TXEMPTY] = ~tx_valid;
        prdata_next[`TWS_ST_GCALL]   = gcall_reg;
        prdata_next[`TWS_ST_READ]    = dir_reg;
        prdata_next[`TWS_ST_ACTIVE]  = (st_reg != TWS_IDLE);
        prdata_next[`TWS_ST_TXFULL]  = ~tx_in_ready;
        prdata_next[`TWS_ST_RXEMPTY] = ~rx_valid;
      end else if (sel_rx) begin
        prdata_next[7:0] = rx_valid ? rx_data : 8'h00;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `TWS_CTRL_RST;
      rxfull_reg <= 1'b0;
      gcall_reg  <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      rxfull_reg <= rxfull_next;
      gcall_reg  <= gcall_next;
      prdata_reg <= prdata_next;
    end
  end

  tws_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (tx_flush | ctrl_reg[`TWS_CTRL_FLUSH]),
    .in_valid  (access & pwrite & sel_tx),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_valid),
    .out_ready (tx_pop),
    .out_data  (tx_data)
  );
  tws_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (1'b0),
    .in_valid  (rx_push),
    .in_ready  (rx_ready),
    .in_data   (sh_reg),
    .out_valid (rx_valid),
    .out_ready (done & ~pwrite & sel_rx),
    .out_data  (rx_data)
  );

  // Transfer state machine driven by the synchronised bus edges
  logic [3:0] cnt_reg, cnt_next;
  logic       sda_reg, sda_next, ack_reg, ack_next, ev_hold, load, abort, lim_hit;
  logic [7:0] hold_reg, hold_next;
  assign lim_hit = ctrl_reg[`TWS_CTRL_LIMIT] & (msg_reg == 8'(DEPTH));

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    sda_next = sda_reg;
    dir_next = dir_reg;
    ack_next = ack_reg;
    msg_next = msg_reg;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    tx_flush = 1'b0;
    set_full = 1'b0;
    set_gc   = 1'b0;
    ev_hold  = 1'b0;
    load     = 1'b0;
    abort    = 1'b0;
    if (start_ev && ctrl_reg[`TWS_CTRL_EN]) begin
      st_next  = TWS_ADDR;
      cnt_next = 4'h0;
      sda_next = 1'b0;
      msg_next = 8'h00;
      ev_hold  = 1'b1;
    end else if (stop_ev) begin
      // Only a stop after a stored data byte marks the buffer full
      if (st_reg == TWS_RXCHK ||
          (st_reg == TWS_RXBYTE && cnt_reg <= 4'h1 && msg_reg != 8'h00)) begin
        set_full = 1'b1;
      end
      abort = 1'b1;
    end else begin
      if (scl_rise && st_reg inside {TWS_ADDR, TWS_RXBYTE, TWS_RXCHK, TWS_TXBYTE}) begin
        cnt_next = cnt_reg + 4'h1;
        if (st_reg != TWS_TXBYTE) begin
          sh_next = {sh_reg[6:0], sda_f};
        end
      end
      if (scl_fall && cnt_reg == `TWS_BYTE_BITS &&
          st_reg inside {TWS_ADDR, TWS_RXBYTE, TWS_TXBYTE}) begin
        ev_hold = 1'b1;
      end
      unique case (st_reg)
        TWS_IDLE: begin
        end
        TWS_ADDR: begin
          if (scl_fall && cnt_reg == `TWS_BYTE_BITS) begin
            if (sh_reg[7:1] == 7'h00 || sh_reg[7:1] == own_addr) begin
              set_gc   = (sh_reg[7:1] == 7'h00);
              dir_next = sh_reg[0];
              if (sh_reg[0] && !tx_valid) begin
                abort = 1'b1;
              end else if (!sh_reg[0] && (rxfull_reg || !rx_ready)) begin
                abort = 1'b1;
              end else begin
                sda_next = 1'b1;
                st_next  = TWS_ADDRACK;
              end
            end else begin
              abort = 1'b1;
            end
          end
        end
        TWS_ADDRACK: begin
          if (scl_fall) begin
            if (dir_reg) begin
              load = 1'b1;
            end else begin
              sda_next = 1'b0;
              cnt_next = 4'h0;
              st_next  = TWS_RXBYTE;
            end
          end
        end
        TWS_TXBYTE: begin
          if (scl_fall) begin
            if (cnt_reg == `TWS_BYTE_BITS) begin
              sda_next = 1'b0;
              st_next  = TWS_TXACK;
            end else begin
              sh_next  = {sh_reg[6:0], 1'b0};
              sda_next = ~sh_reg[6];
            end
          end
        end
        TWS_TXACK: begin
          if (scl_rise) begin
            ack_next = ~sda_f;
          end
          if (scl_fall) begin
            if (!ack_reg) begin
              tx_flush = 1'b1;
              abort    = 1'b1;
            end else begin
              load = 1'b1;
            end
          end
        end
        TWS_RXBYTE: begin
          if (scl_fall && cnt_reg == `TWS_BYTE_BITS) begin
            if (rxfull_reg || !rx_ready || lim_hit) begin
              abort = 1'b1;
            end else begin
              rx_push  = 1'b1;
              msg_next = msg_reg + 8'h01;
              sda_next = 1'b1;
              st_next  = TWS_RXACK;
            end
          end
        end
        TWS_RXACK: begin
          if (scl_fall) begin
            sda_next = 1'b0;
            cnt_next = 4'h0;
            st_next  = TWS_RXCHK;
          end
        end
        TWS_RXCHK: begin
          if (scl_rise) begin
            st_next = TWS_RXBYTE;
          end
        end
      endcase
      if (load) begin
        if (!tx_valid) begin
          abort = 1'b1;
        end else if (lim_hit) begin
          abort = 1'b1;
        end else begin
          tx_pop   = 1'b1;
          sh_next  = tx_data;
          sda_next = ~tx_data[7];
          cnt_next = 4'h0;
          msg_next = msg_reg + 8'h01;
          st_next  = TWS_TXBYTE;
        end
      end
    end
    if (abort) begin
      st_next  = TWS_IDLE;
      sda_next = 1'b0;
      cnt_next = 4'h0;
    end
  end

  // Clock stretch: hold SCL low for the service time once it is low
  always_comb begin
    hold_next = hold_reg;
    // An abort releases the clock at once, even on a byte event
    if (abort) begin
      hold_next = 8'h00;
    end else if (ev_hold) begin
      hold_next = 8'(`TWS_HOLD_CYC);
    end else if (hold_reg != 8'h00 && !scl_f) begin
      hold_next = hold_reg - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= TWS_IDLE;
      cnt_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      sda_reg  <= 1'b0;
      dir_reg  <= 1'b0;
      ack_reg  <= 1'b0;
      msg_reg  <= 8'h00;
      hold_reg <= 8'h00;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      sda_reg  <= sda_next;
      dir_reg  <= dir_next;
      ack_reg  <= ack_next;
      msg_reg  <= msg_next;
      hold_reg <= hold_next;
    end
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe   = (hold_reg != 8'h00);
  assign sda_oe   = sda_reg;
  assign wake_o   = start_ev & ctrl_reg[`TWS_CTRL_EN];
  assign active_o = (st_reg != TWS_IDLE);
endmodule

// >>> tws_slave_asserts.sv
// Port-level checks on the two-wire slave, bound to every instance
module tws_slave_asserts (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bus lines
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Power
  input wire logic        wake_o,
  input wire logic        active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");
  a_wake_active: assert property (wake_o |-> ##[0:4] active_o)
    else $error("start did not make the slave active");
  a_start_hold: assert property (wake_o |-> ##[0:30] scl_oe)
    else $error("clock not held after start");
  a_hold_ends: assert property ($rose(scl_oe) |-> ##[1:40] !scl_oe)
    else $error("clock hold not released");
  a_sda_clk_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line moved while clock high");
  a_open_drain: assert property ((sda_oe || scl_oe) |-> !(sda_o || scl_o))
    else $error("driven line not pulled low");
  a_idle_sda: assert property (!active_o [*8] |-> !sda_oe)
    else $error("data line held while idle");
  a_idle_scl: assert property (!active_o [*8] |-> !scl_oe)
    else $error("clock line held while idle");
endmodule

bind tws_slave tws_slave_asserts tws_slave_asserts_inst (.*);

// >>> tws_master_model.sv
// Behavioural two-wire bus master with pull-ups on both lines
module tws_master_model (
  // Clock
  input wire logic pclk,
  // Slave pull-downs
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Wire levels
  output logic     scl,
  output logic     sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 10;
  logic m_scl_low = 1'b0;
  logic m_sda_low = 1'b0;
  int   stall     = 0;
  int   tmo       = 0;
  assign scl = !(m_scl_low || scl_oe);
  assign sda = !(m_sda_low || sda_oe);
  task automatic waitq(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pulse(output logic v);
    int i;
    m_scl_low <= 1'b0;
    for (i = 0; i < 200 && !scl; i++) @(posedge pclk);
    if (i == 200) tmo++;
    waitq(Q + stall);
    v = sda;
    m_scl_low <= 1'b1;
    waitq(Q);
  endtask
  task automatic start();
    m_sda_low <= 1'b0;
    waitq(Q);
    m_scl_low <= 1'b0;
    waitq(2 * Q);
    m_sda_low <= 1'b1;
    waitq(Q);
    m_scl_low <= 1'b1;
    waitq(Q);
  endtask
  task automatic stop();
    m_sda_low <= 1'b1;
    waitq(Q);
    m_scl_low <= 1'b0;
    waitq(Q);
    m_sda_low <= 1'b0;
    waitq(2 * Q);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      m_sda_low <= !b[i];
      waitq(Q);
      pulse(v);
    end
    m_sda_low <= 1'b0;
    waitq(Q);
    pulse(v);
    ack = !v;
  endtask
  task automatic rd_byte(output logic [7:0] b, input logic ack);
    logic v;
    m_sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      waitq(Q);
      pulse(v);
      b[i] = v;
    end
    m_sda_low <= ack;
    waitq(Q);
    pulse(v);
    m_sda_low <= 1'b0;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench: APB register access plus two-wire transfers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl;
  logic        sda;
  logic [31:0] q;
  logic        e;
  logic        ack;
  logic [7:0]  b;
  logic [7:0]  txb [4] = '{8'h81, 8'h7E, 8'hC3, 8'h18};
  int          err_count = 0;
  int          checks    = 0;
  initial begin
    forever #5 pclk = ~pclk;
  end
  tws_slave #(.DEPTH(4)) tws_slave_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .wake_o(), .active_o());
  tws_master_model tws_master_model_inst (.pclk(pclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 200 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 200) begin
      err_count++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string w);
    apb(1'b0, a, 32'h0000_0000);
    chk(w, x, q);
  endtask
  task automatic hdr(input logic [7:0] a8, input logic x);
    tws_master_model_inst.start();
    tws_master_model_inst.wr_byte(a8, ack);
    chk("address ack", {31'h0000_0000, x}, {31'h0000_0000, ack});
  endtask
  task automatic put(input logic [7:0] d, input logic x);
    tws_master_model_inst.wr_byte(d, ack);
    chk("data ack", {31'h0000_0000, x}, {31'h0000_0000, ack});
  endtask
  task automatic fin(input logic [31:0] st, input string w);
    tws_master_model_inst.stop();
    repeat (20) @(posedge pclk);
    rd(8'h04, st, w);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(8'h04, 32'h0000_0042, "status reset");
    apb(1'b1, 8'h00, 32'h0000_012A);
    rd(8'h00, 32'h0000_012A, "ctrl");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
    $display("test registers done");
    hdr(8'h54, 1'b1);
    put(8'hA5, 1'b1);
    put(8'h3C, 1'b1);
    fin(32'h0000_0003, "status after write");
    rd(8'h0C, 32'h0000_00A5, "rx byte 0");
    rd(8'h0C, 32'h0000_003C, "rx byte 1");
    hdr(8'h54, 1'b0);
    fin(32'h0000_0043, "status refused write");
    apb(1'b1, 8'h04, 32'h0000_0001);
    $display("test master write done");
    for (int i = 0; i < 4; i++) apb(1'b1, 8'h08, {24'h00_0000, txb[i]});
    rd(8'h04, 32'h0000_0060, "status tx full");
    hdr(8'h55, 1'b1);
    for (int i = 0; i < 3; i++) begin
      tws_master_model_inst.stall = (i == 1) ? 15 : 0;
      tws_master_model_inst.rd_byte(b, i < 2);
      chk("tx byte", {24'h00_0000, txb[i]}, {24'h00_0000, b});
    end
    fin(32'h0000_004A, "status after nack");
    hdr(8'h55, 1'b0);
    fin(32'h0000_004A, "status tx empty read");
    hdr(8'h20, 1'b0);
    fin(32'h0000_004A, "status mismatch");
    $display("test master read done");
    hdr(8'h00, 1'b1);
    put(8'h11, 1'b1);
    fin(32'h0000_0007, "status general call");
    rd(8'h0C, 32'h0000_0011, "rx general call");
    apb(1'b1, 8'h04, 32'h0000_0005);
    hdr(8'h54, 1'b1);
    put(8'h99, 1'b1);
    hdr(8'h54, 1'b1);
    fin(32'h0000_0002, "status repeated start");
    rd(8'h0C, 32'h0000_0099, "rx before restart");
    $display("test restart done");
    apb(1'b1, 8'h00, 32'h0000_032A);
    hdr(8'h54, 1'b1);
    rd(8'h04, 32'h0000_0052, "status active");
    for (int i = 0; i < 5; i++) put(8'h40 + 8'(i), i < 4);
    fin(32'h0000_0002, "status limit");
    for (int i = 0; i < 4; i++) rd(8'h0C, 32'h0000_0040 + i, "rx limit");
    $display("test limit done");
    chk("link wait timeouts", 32'h0000_0000, tws_master_model_inst.tmo);
    give_verdict();
  end
endmodule
